// [hdl/vcal_params.svh]
`ifndef VCAL_PARAMS_SVH
`define VCAL_PARAMS_SVH
// bus address: upper five bits fixed, straps fill bits 2:1
`define VCAL_ADDR_HI 5'h0A
// register indexes
`define VCAL_REG_DATA 8'h00
`define VCAL_REG_ACR 8'h02
// reset values
`define VCAL_ACR_RST 1'b0
`define VCAL_PRESET_RST 7'h00
// access control: select bit position in the written byte
`define VCAL_RSB_POS 7
// programming cycle length in ns and in 4 ns clock cycles
`define VCAL_PROG_NS 10000000
`define VCAL_CLK_NS 4
`define VCAL_PROG_CYC (`VCAL_PROG_NS / `VCAL_CLK_NS)
`endif

// [hdl/vcal_pkg.sv]
`default_nettype none
package vcal_pkg;
  // byte engine states
  typedef enum logic [2:0] {
    vcal_idle,
    vcal_rx,
    vcal_rx_ack,
    vcal_tx,
    vcal_tx_ack,
    vcal_ignore
  } vcal_state_e;
endpackage
`default_nettype wire

// [hdl/vcal_i2c_slave.sv]
`timescale 1ns/10ps
`default_nettype none
`include "vcal_params.svh"
// Summary of operation
// - target only; never drives clock line
// - falling data with clock high is start
// - rising data with clock high is stop
// - data changes only while clock low
// - one data bit per clock pulse
// - transfers bracketed by start and stop
// - acknowledge each byte once addressed, except data bytes to registers other than 00h and 02h and refused program writes
// - acknowledge low through clock high period
// - release data after master's final nack
// - no acknowledge during nonvolatile programming
// - address polling acknowledged once programming ends
// - refuse program when gate supply low
// - program only after a wiper-only write since last
// - address from two straps, 50h grounded
// - data register 00h, access control 02h
// - select bit chooses wiper only or both
// - ignore bus while programming runs
module vcal_i2c_slave #(
  parameter int PROG_CYC = `VCAL_PROG_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic address_strap_low,
  input wire logic address_strap_high,
  input wire logic gate_on_supply,
  output logic [6:0] wiper,
  output logic [6:0] nonvolatile_preset,
  output logic busy
);
  // two-stage synchronisers; stage one is read only by stage two
  logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
  logic gon_s1, gon_s2;
  logic a0_s1, a0_s2, a1_s1, a1_s2;
  always_ff @(posedge clk)
  begin
    scl_s1 <= scl;
    scl_s2 <= scl_s1;
    scl_d <= scl_s2;
    sda_s1 <= sda_in;
    sda_s2 <= sda_s1;
    sda_d <= sda_s2;
    gon_s1 <= gate_on_supply;
    gon_s2 <= gon_s1;
    a0_s1 <= address_strap_low;
    a0_s2 <= a0_s1;
    a1_s1 <= address_strap_high;
    a1_s2 <= a1_s1;
  end
  // events seen on the synchronised lines
  logic scl_rise, scl_fall, start_ev, stop_ev;
  assign scl_rise = scl_s2 & ~scl_d;
  assign scl_fall = ~scl_s2 & scl_d;
  assign start_ev = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign stop_ev = scl_s2 & scl_d & ~sda_d & sda_s2;
  logic [7:0] own_addr; // straps fill bits 2:1 of address byte
  assign own_addr = {`VCAL_ADDR_HI, a1_s2, a0_s2, 1'b0};
  // transaction state
  vcal_pkg::vcal_state_e state, next_state;
  logic [7:0] shreg, next_shreg; // byte being shifted
  logic [3:0] bitcnt, next_bitcnt; // bits left in byte
  logic [1:0] bytenum, next_bytenum; // 0 addr, 1 reg, 2 data
  logic reading, next_reading; // address had read bit
  logic [7:0] regsel, next_regsel; // register index
  logic register_select_bit, next_rsb; // register select bit
  logic ack_now, next_ack_now; // drive ack in this slot
  logic [6:0] next_wiper, next_preset;
  logic dirty, next_dirty; // any wiper-only write since last program
  logic [31:0] pcnt, next_pcnt; // programming countdown
  logic next_busy, next_sda_oe;
  // next-state computation for the byte engine
  always_comb
  begin
    next_state = state;
    next_shreg = shreg;
    next_bitcnt = bitcnt;
    next_bytenum = bytenum;
    next_reading = reading;
    next_regsel = regsel;
    next_rsb = register_select_bit;
    next_ack_now = ack_now;
    next_wiper = wiper;
    next_preset = nonvolatile_preset;
    next_dirty = dirty;
    next_pcnt = pcnt;
    next_busy = busy;
    next_sda_oe = sda_oe;
    if (busy)
    begin
      // bus ignored while programming runs
      next_state = vcal_pkg::vcal_idle;
      next_sda_oe = 1'b0;
      if (pcnt <= 32'd1)
        next_busy = 1'b0;
      next_pcnt = pcnt - 32'd1;
    end
    else if (stop_ev)
    begin
      // stop ends any transfer and releases data
      next_state = vcal_pkg::vcal_idle;
      next_sda_oe = 1'b0;
    end
    else if (start_ev)
    begin
      // start or repeated start opens address byte
      next_state = vcal_pkg::vcal_rx;
      next_bitcnt = 4'd8;
      next_bytenum = 2'd0;
      next_sda_oe = 1'b0;
    end
    else
    begin
      case (state)
        vcal_pkg::vcal_idle:
          next_sda_oe = 1'b0;
        vcal_pkg::vcal_rx:
        begin
          if (scl_rise)
          begin
            // sample during clock high
            next_shreg = {shreg[6:0], sda_s2};
            next_bitcnt = bitcnt - 4'd1;
          end
          if (scl_fall && bitcnt == 4'd0)
          begin
            // byte done once eight rises are in; the fall
            // right after a start finds the count still at 8
            next_ack_now = 1'b1;
            if (bytenum == 2'd0)
            begin
              next_reading = shreg[0];
              next_ack_now = (shreg[7:1] == own_addr[7:1]);
            end
            else if (bytenum == 2'd1)
              next_regsel = shreg;
            else if (regsel == `VCAL_REG_ACR)
              next_rsb = shreg[`VCAL_RSB_POS];
            else if (regsel == `VCAL_REG_DATA && !register_select_bit)
              next_ack_now = dirty && gon_s2;
            else if (regsel != `VCAL_REG_DATA)
              next_ack_now = 1'b0;
            next_state = vcal_pkg::vcal_rx_ack;
            next_sda_oe = next_ack_now;
          end
        end
        vcal_pkg::vcal_rx_ack:
        begin
          // ack stays low until the ninth clock falls
          if (scl_fall)
          begin
            next_sda_oe = 1'b0;
            next_bitcnt = 4'd8;
            if (!ack_now)
              next_state = vcal_pkg::vcal_ignore;
            else if (bytenum == 2'd0 && reading)
            begin
              next_state = vcal_pkg::vcal_tx;
              next_bitcnt = 4'd7;
              next_shreg = {1'b0, register_select_bit ? wiper : nonvolatile_preset};
              next_sda_oe = ~next_shreg[7];
            end
            else
            begin
              next_state = vcal_pkg::vcal_rx;
              if (bytenum == 2'd2 && regsel == `VCAL_REG_DATA)
              begin
                // msb ignored; select bit picks target
                next_wiper = shreg[6:0];
                next_dirty = register_select_bit | (shreg[6:0] != wiper);
                if (!register_select_bit)
                begin
                  next_preset = shreg[6:0];
                  next_dirty = 1'b0;
                  next_busy = 1'b1;
                  next_pcnt = 32'(PROG_CYC);
                end
              end
              if (bytenum != 2'd2)
                next_bytenum = bytenum + 2'd1;
            end
          end
        end
        vcal_pkg::vcal_tx:
        begin
          // shift one bit per clock low, open drain
          if (scl_fall)
          begin
            if (bitcnt == 4'd0)
            begin
              next_state = vcal_pkg::vcal_tx_ack;
              next_sda_oe = 1'b0;
            end
            else
            begin
              next_shreg = {shreg[6:0], 1'b0};
              next_sda_oe = ~shreg[6];
              next_bitcnt = bitcnt - 4'd1;
            end
          end
        end
        vcal_pkg::vcal_tx_ack:
        begin
          // master nack: keep data released for stop
          if (scl_rise)
            next_state = sda_s2 ? vcal_pkg::vcal_ignore
                                : vcal_pkg::vcal_tx_ack;
          if (scl_fall && !sda_d)
          begin
            next_state = vcal_pkg::vcal_tx;
            next_bitcnt = 4'd7;
            next_shreg = {1'b0, register_select_bit ? wiper : nonvolatile_preset};
            next_sda_oe = ~next_shreg[7];
          end
        end
        vcal_pkg::vcal_ignore:
          next_sda_oe = 1'b0;
        default:
          next_state = vcal_pkg::vcal_idle;
      endcase
    end
  end
  // state registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= vcal_pkg::vcal_idle;
      shreg <= 8'h00;
      bitcnt <= 4'd8;
      bytenum <= 2'd0;
      reading <= 1'b0;
      regsel <= 8'h00;
      register_select_bit <= `VCAL_ACR_RST;
      ack_now <= 1'b0;
      wiper <= `VCAL_PRESET_RST;
      nonvolatile_preset <= `VCAL_PRESET_RST;
      dirty <= 1'b0;
      pcnt <= 32'd0;
      busy <= 1'b0;
      sda_oe <= 1'b0;
    end
    else
    begin
      state <= next_state;
      shreg <= next_shreg;
      bitcnt <= next_bitcnt;
      bytenum <= next_bytenum;
      reading <= next_reading;
      regsel <= next_regsel;
      register_select_bit <= next_rsb;
      ack_now <= next_ack_now;
      wiper <= next_wiper;
      nonvolatile_preset <= next_preset;
      dirty <= next_dirty;
      pcnt <= next_pcnt;
      busy <= next_busy;
      sda_oe <= next_sda_oe;
    end
  end
  // data is only ever pulled low; clock is never driven
  always_ff @(posedge clk)
    sda_out <= 1'b0;
  // assertions
  sequence prog_start_s;
    !busy ##1 busy;
  endsequence
  busy_silent_a: assert property (@(posedge clk) disable iff (rst)
    busy |-> !sda_oe) else $error("data driven while busy");
  busy_len_a: assert property (@(posedge clk) disable iff (rst)
    prog_start_s |-> busy [*8]) else $error("busy too short");
  drive_low_a: assert property (@(posedge clk) disable iff (rst)
    sda_oe |-> !sda_out) else $error("data driven high");
  ack_hold_a: assert property (@(posedge clk) disable iff (rst)
    (state == vcal_pkg::vcal_rx_ack && sda_oe && scl_s2)
    |=> sda_oe || busy) else $error("ack dropped early");
  stop_idle_a: assert property (@(posedge clk) disable iff (rst)
    stop_ev && !busy |=> state == vcal_pkg::vcal_idle)
    else $error("stop not seen");
  start_rx_a: assert property (@(posedge clk) disable iff (rst)
    start_ev && !busy && !stop_ev |=> state == vcal_pkg::vcal_rx)
    else $error("start not seen");
  stable_high_a: assert property (@(posedge clk) disable iff (rst)
    scl_d && scl_s2 && state == vcal_pkg::vcal_tx
    |=> $stable(sda_oe)) else $error("data moved in clock high");
  preset_prog_a: assert property (@(posedge clk) disable iff (rst)
    $changed(nonvolatile_preset) |-> busy)
    else $error("preset changed without cycle");
  nack_free_a: assert property (@(posedge clk) disable iff (rst)
    state == vcal_pkg::vcal_ignore |-> !sda_oe)
    else $error("data held after nack");
endmodule // vcal_i2c_slave
`default_nettype wire

// [verification/vcal_master.sv]
`timescale 1ns/10ps
`default_nettype none
// bus master model; a bit slot is 48 ns, clock idles high
module vcal_master (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  localparam int Q = 12; // quarter of the 48 ns bit slot
  // idle bus: both lines released high
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // start, also used as repeated start; calls begin on a clock edge,
  // so every change lands on an edge and goes out non-blocking
  task automatic start;
    #Q sda_low <= 1'b0;
    #Q scl <= 1'b1;
    #Q sda_low <= 1'b1;
    #Q scl <= 1'b0;
  endtask
  task automatic stop;
    #Q sda_low <= 1'b1;
    #Q scl <= 1'b1;
    #Q sda_low <= 1'b0;
    #Q;
  endtask
  // data set mid low phase, sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    #Q sda_low <= !b;
    #Q scl <= 1'b1;
    #Q r = sda;
    #Q scl <= 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // last byte answered with a withheld acknowledge
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, d[i]);
    end
    bit_io(last, r);
  endtask
endmodule // vcal_master
`default_nettype wire

// [verification/vcal_i2c_slave_test.sv]
`timescale 1ns/10ps
`default_nettype none
module vcal_i2c_slave_test;
  localparam int PC = 400; // short programming time for sim
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sl = 1'b0;
  logic sh = 1'b0;
  logic gate = 1'b1;
  logic scl, sda_low, sda_out, sda_oe, busy;
  logic [6:0] wiper, preset;
  int bad_count = 0;
  int n_compared = 0;
  // open drain wire with pull-up
  wire sda = !(sda_low | (sda_oe & !sda_out));
  always #2 clk = ~clk;
  vcal_master i_m (.scl(scl), .sda_low(sda_low), .sda(sda));
  vcal_i2c_slave #(.PROG_CYC(PC)) i_dut (
    .clk(clk), .rst(rst), .scl(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe),
    .address_strap_low(sl), .address_strap_high(sh),
    .gate_on_supply(gate), .wiper(wiper),
    .nonvolatile_preset(preset), .busy(busy));
  task automatic check(string nm, logic [7:0] s, logic [7:0] e);
    n_compared++;
    if (s !== e)
    begin
      bad_count++;
      $display("wrong value %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic finish_test;
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // write: address, register, value; acks packed msb first
  task automatic wr(logic [7:0] r, d, output logic [2:0] a);
    i_m.start();
    i_m.wbyte(8'h50, a[2]);
    i_m.wbyte(r, a[1]);
    i_m.wbyte(d, a[0]);
    i_m.stop();
  endtask
  task automatic rd(logic [7:0] r, output logic [7:0] d);
    logic a;
    i_m.start();
    i_m.wbyte(8'h50, a);
    i_m.wbyte(r, a);
    i_m.start();
    i_m.wbyte(8'h51, a);
    i_m.rbyte(1'b1, d);
    i_m.stop();
  endtask
  // every strap setting, right and wrong address bytes
  task automatic t_addr;
    logic a;
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk) {sh, sl} <= 2'(k);
      i_m.start();
      i_m.wbyte({5'h0A, 2'(k), 1'b0}, a);
      i_m.stop();
      check("ack", 8'(a), 8'h01);
      i_m.start();
      i_m.wbyte({5'h0A, ~2'(k), 1'b0}, a);
      i_m.stop();
      check("nack", 8'(a), 8'h00);
    end
    check("sda out", 8'(sda_out), 8'h00);
    @(posedge clk) {sh, sl} <= 2'b00;
    $display("test addr done");
  endtask
  // wiper-only write, msb dropped, read back, bad register
  task automatic t_wiper;
    logic [2:0] a;
    logic [7:0] d;
    wr(8'h02, 8'h80, a);
    check("acks", 8'(a), 8'h07);
    wr(8'h00, 8'h95, a);
    check("wiper", 8'(wiper), 8'h15);
    check("preset", 8'(preset), 8'h00);
    rd(8'h00, d);
    check("read", d, 8'h15);
    wr(8'h01, 8'h00, a);
    check("reg nack", 8'(a), 8'h06);
    $display("test wiper done");
  endtask
  // program refused, accepted with polling, refused unchanged
  task automatic t_prog;
    logic [2:0] a;
    logic p;
    int n;
    wr(8'h02, 8'h00, a);
    @(posedge clk) gate <= 1'b0;
    wr(8'h00, 8'h33, a);
    check("low gate", 8'(a[0]), 8'h00);
    check("preset", 8'(preset), 8'h00);
    @(posedge clk) gate <= 1'b1;
    wr(8'h00, 8'h33, a);
    check("prog ack", 8'(a), 8'h07);
    check("busy", 8'(busy), 8'h01);
    check("preset", 8'(preset), 8'h33);
    n = 0;
    p = 1'b0;
    while (!p && n < 20)
    begin
      i_m.start();
      i_m.wbyte(8'h50, p);
      i_m.stop();
      n = n + (p ? 0 : 1);
    end
    check("polled", 8'(n > 0 && n < 20), 8'h01);
    check("busy end", 8'(busy), 8'h00);
    wr(8'h00, 8'h33, a);
    check("same", 8'(a[0]), 8'h00);
    $display("test prog done");
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_addr();
    t_wiper();
    t_prog();
    finish_test();
  end
  // hang guard, well beyond the expected run
  initial
  begin
    #200000;
    bad_count++;
    finish_test();
  end
endmodule // vcal_i2c_slave_test
`default_nettype wire
